/* erf_cfg.svh */
// Constants for the receive frame checker with link fault signalling.
// Assumes an APB host and a byte-wide receive link of data and control characters.
// What this block does
// - Every packet needs start control byte 0xfb
// - Optional strict compare of SFD and preamble
// - Control bit 4 preamble, bit 3 SFD
// - Bad start ignored; failed strict check drops packet
// - Stray control ends packet, flags malformed and FCS
// - No second end after a late terminate
// - Length/type below 0x600 is length, else type
// - 0x8100 tagged, 0x8808 control, others forwarded
// - Pause and PFC opcodes flagged, no action
// - Frames under 64 bytes are undersized
// - Oversize limit: maximum plus tag bytes
// - Count payload when length field is a length
// - Payload bounds 46/42/38 up to 1536 exclusive
// - Length failures delivered, error bits 2-4
// - A length field above payload, or payload out of bounds, is an error
// - CRC error shown together with end of packet
// - CRC stripped unless keep setting is set
// - Fault status outputs follow link continuously
// - Bidirectional local fault: stop data, send RF
// - Bidirectional remote fault: idle only until cleared
// - Bit 0 clear: normal; bits 0,3: RF only
// - Unidirectional: bit 2 mutes RF, else idle column
`ifndef ERF_CFG_SVH
`define ERF_CFG_SVH
// Register word indexes; byte address is four times the index
`define ERF_IDX_FAULT_CFG 14'h0405
`define ERF_IDX_RX_CTL 14'h050a
`define ERF_IDX_MAX_SIZE 14'h050b
`define ERF_IDX_CRC_KEEP 14'h050c
`define ERF_IDX_STATUS 14'h050d
// Field positions
`define ERF_RXCTL_PRE_BIT 4
`define ERF_RXCTL_SFD_BIT 3
// Reset values
`define ERF_FAULT_CFG_RST 4'h0
`define ERF_MAX_SIZE_RST 16'h05ee
// Link codes and frame figures
`define ERF_CH_START 8'hfb
`define ERF_CH_TERM 8'hfd
`define ERF_SFD 8'hd5
`define ERF_PRE_BYTE 8'h55
`define ERF_PRE_LEN 3'h6
`define ERF_TYPE_SPLIT 16'h0600
`define ERF_TYPE_VLAN 16'h8100
`define ERF_TYPE_CTRL 16'h8808
`define ERF_OP_PAUSE 16'h0001
`define ERF_OP_PFC 16'h0101
`define ERF_MIN_FRAME 16'h0040
`define ERF_MIN_PAYLOAD 16'h002e
`define ERF_LT_POS 5'h0c
`define ERF_TAG_BYTES 5'h04
`define ERF_LT_FCS_BYTES 16'h0006
`define ERF_CRC_POLY 32'hedb88320
`define ERF_CRC_RESIDUE 32'hdebb20e3
`endif

/* erf_pkg.sv */
// Types for the receive frame checker.
// Assumes erf_cfg.svh is on the include path.
package erf_pkg;
  // Receive sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_PRE = 5'h02,
    ST_DATA = 5'h04,
    ST_DRAIN = 5'h08,
    ST_DROP = 5'h10
  } erf_state_t;

  // One link character per cycle
  typedef struct packed {
    logic valid;
    logic ctrl;
    logic [7:0] data;
  } erf_link_t;

  // Client side stream with errors and frame kind
  typedef struct packed {
    logic valid;
    logic sop;
    logic eop;
    logic [7:0] data;
    logic [4:0] err;
    logic [4:0] stat;
  } erf_client_t;

  // Whole state of the checker
  typedef struct packed {
    erf_state_t state;
    logic [2:0] pre_cnt;
    logic pre_bad;
    logic [4:0][7:0] dly;
    logic [4:0] dly_v;
    logic sop_pend;
    logic [15:0] cnt;
    logic [15:0] lt;
    logic [4:0] lt_pos;
    logic vlan;
    logic svlan;
    logic ctl;
    logic [15:0] op;
    logic [31:0] crc;
    logic [4:0] hold_err;
    logic [4:0] hold_stat;
    erf_client_t out;
    logic [3:0] cfg_fault;
    logic chk_pre;
    logic chk_sfd;
    logic crc_keep;
    logic [15:0] max_size;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic lf;
    logic rf;
    logic tx_de;
    logic tx_rf;
    logic tx_idle;
  } erf_st_t;
endpackage : erf_pkg

/* erf_rx_check.sv */
// Receive frame checker, CRC strip and link fault transmit gating.
// Assumes one clock, synchronous inputs and an APB master with 32-bit data.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "erf_cfg.svh"
module erf_rx_check
  import erf_pkg::*;
#(
  parameter bit STRICT_EN = 1'b1,
  parameter logic [15:0] MAX_RX_SIZE = `ERF_MAX_SIZE_RST
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire erf_link_t rx_in,
  input wire logic local_fault_in,
  input wire logic remote_fault_in,
  output erf_client_t rx_out,
  output logic local_fault_status,
  output logic remote_fault_status,
  output logic tx_data_enable,
  output logic tx_send_rf,
  output logic tx_idle_column
);

  // ****************************************
  // State and helpers
  // ****************************************
  erf_st_t s_reg; // Registered state
  erf_st_t s_next; // Next state

  // Reflected CRC32 over one byte
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] x;
    x = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++)
    begin
      x = x[0] ? ((x >> 1) ^ `ERF_CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction : crc_byte

  // Outputs come straight from the state flops
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign rx_out = s_reg.out;
  assign local_fault_status = s_reg.lf;
  assign remote_fault_status = s_reg.rf;
  assign tx_data_enable = s_reg.tx_de;
  assign tx_send_rf = s_reg.tx_rf;
  assign tx_idle_column = s_reg.tx_idle;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    logic [13:0] idx; // Word index of the access
    logic [15:0] lp; // Length/type position widened
    logic [15:0] extra; // Tag bytes ahead of the client length
    logic [15:0] pay; // Payload bytes seen
    logic [15:0] ltn; // Length/type after this byte
    logic [4:0] ferr; // Errors at end of frame
    logic [4:0] fstat; // Frame kind at end of frame
    logic len_chk; // Field holds a length
    logic pre_on; // Preamble compare active
    logic sfd_on; // SFD compare active
    idx = paddr[15:2];
    lp = {11'h000, s_reg.lt_pos};
    extra = lp - {11'h000, `ERF_LT_POS};
    pay = (s_reg.cnt > lp + `ERF_LT_FCS_BYTES) ? s_reg.cnt - lp - `ERF_LT_FCS_BYTES : 16'h0000;
    ltn = {s_reg.lt[7:0], rx_in.data};
    len_chk = s_reg.lt < `ERF_TYPE_SPLIT;
    pre_on = STRICT_EN && s_reg.chk_pre;
    sfd_on = STRICT_EN && s_reg.chk_sfd;
    ferr = 5'h00;
    ferr[1] = s_reg.crc != `ERF_CRC_RESIDUE;
    ferr[2] = s_reg.cnt < `ERF_MIN_FRAME;
    ferr[3] = s_reg.cnt > s_reg.max_size + extra;
    // A field larger than the payload, or a payload under the minimum or at 0x600 and above, is an error; more data is padding
    ferr[4] = len_chk && (s_reg.lt > pay || pay < `ERF_MIN_PAYLOAD - extra || pay >= `ERF_TYPE_SPLIT);
    fstat = {s_reg.ctl && s_reg.op == `ERF_OP_PFC, s_reg.ctl && s_reg.op == `ERF_OP_PAUSE,
             s_reg.ctl, s_reg.svlan, s_reg.vlan};
    s_next = s_reg;
    s_next.out.valid = 1'b0;
    s_next.out.sop = 1'b0;
    s_next.out.eop = 1'b0;
    s_next.out.err = 5'h00;
    s_next.out.stat = 5'h00;
    s_next.pready = 1'b0;
    s_next.pslverr = 1'b0;

    // Status follows the link whatever the configuration
    s_next.lf = local_fault_in;
    s_next.rf = remote_fault_in;

    // Transmit gating from configuration and received status
    s_next.tx_idle = 1'b0;
    if (!s_reg.cfg_fault[0])
    begin
      s_next.tx_de = 1'b1;
      s_next.tx_rf = 1'b0;
    end
    else if (s_reg.cfg_fault[3])
    begin
      s_next.tx_de = 1'b0;
      s_next.tx_rf = 1'b1;
    end
    else if (s_reg.cfg_fault[1])
    begin
      // Unidirectional keeps data flowing
      s_next.tx_de = 1'b1;
      s_next.tx_rf = !s_reg.cfg_fault[2] && s_reg.lf && !s_reg.rf;
      s_next.tx_idle = !s_reg.cfg_fault[2] && s_reg.lf && !s_reg.rf;
    end
    else if (s_reg.lf)
    begin
      s_next.tx_de = 1'b0;
      s_next.tx_rf = 1'b1;
    end
    else
    begin
      s_next.tx_de = !s_reg.rf;
      s_next.tx_rf = 1'b0;
    end

    // APB setup cycle prepares the answer for the access cycle
    if (psel && !penable)
    begin
      s_next.pready = 1'b1;
      s_next.prdata = 32'h00000000;
      if (paddr[1:0] != 2'h0)
        s_next.pslverr = 1'b1;
      else
      begin
        case (idx)
          `ERF_IDX_FAULT_CFG: s_next.prdata[3:0] = s_reg.cfg_fault;
          `ERF_IDX_RX_CTL:
          begin
            s_next.prdata[`ERF_RXCTL_PRE_BIT] = s_reg.chk_pre;
            s_next.prdata[`ERF_RXCTL_SFD_BIT] = s_reg.chk_sfd;
          end
          `ERF_IDX_MAX_SIZE: s_next.prdata[15:0] = s_reg.max_size;
          `ERF_IDX_CRC_KEEP: s_next.prdata[0] = s_reg.crc_keep;
          `ERF_IDX_STATUS: s_next.prdata[2:0] = {s_reg.state != ST_IDLE, s_reg.rf, s_reg.lf};
          default: s_next.pslverr = 1'b1;
        endcase
      end
    end
    // Write takes effect on the access cycle that completes
    if (psel && penable && s_reg.pready && pwrite && !s_reg.pslverr)
    begin
      case (idx)
        `ERF_IDX_FAULT_CFG: s_next.cfg_fault = pwdata[3:0];
        `ERF_IDX_RX_CTL:
        begin
          s_next.chk_pre = pwdata[`ERF_RXCTL_PRE_BIT];
          s_next.chk_sfd = pwdata[`ERF_RXCTL_SFD_BIT];
        end
        `ERF_IDX_MAX_SIZE: s_next.max_size = pwdata[15:0];
        `ERF_IDX_CRC_KEEP: s_next.crc_keep = pwdata[0];
        default: s_next.crc_keep = s_reg.crc_keep;
      endcase
    end

    // Receive sequencer
    case (s_reg.state)
      ST_IDLE:
      begin
        // Any other character is simply not a start; stray terminates land here too
        if (rx_in.valid && rx_in.ctrl && rx_in.data == `ERF_CH_START)
        begin
          s_next.state = ST_PRE;
          s_next.pre_cnt = 3'h0;
          s_next.pre_bad = 1'b0;
          s_next.dly_v = 5'h00;
          s_next.sop_pend = 1'b1;
          s_next.cnt = 16'h0000;
          s_next.lt = 16'h0000;
          s_next.lt_pos = `ERF_LT_POS;
          s_next.vlan = 1'b0;
          s_next.svlan = 1'b0;
          s_next.ctl = 1'b0;
          s_next.op = 16'h0000;
          s_next.crc = 32'hffffffff;
        end
      end
      ST_PRE:
      begin
        if (rx_in.valid && rx_in.ctrl)
          s_next.state = ST_IDLE;
        else if (rx_in.valid && s_reg.pre_cnt != `ERF_PRE_LEN)
        begin
          s_next.pre_cnt = s_reg.pre_cnt + 3'h1;
          s_next.pre_bad = s_reg.pre_bad || (pre_on && rx_in.data != `ERF_PRE_BYTE);
        end
        else if (rx_in.valid)
        begin
          // Failed strict compare drops the whole packet
          if (s_reg.pre_bad || (sfd_on && rx_in.data != `ERF_SFD))
            s_next.state = ST_DROP;
          else
            s_next.state = ST_DATA;
        end
      end
      ST_DATA:
      begin
        if (rx_in.valid && !rx_in.ctrl)
        begin
          // Five-byte delay hides the FCS until the terminate is seen
          s_next.dly = {s_reg.dly[3:0], rx_in.data};
          s_next.dly_v = {s_reg.dly_v[3:0], 1'b1};
          if (s_reg.dly_v[4])
          begin
            s_next.out.valid = 1'b1;
            s_next.out.data = s_reg.dly[4];
            s_next.out.sop = s_reg.sop_pend;
            s_next.sop_pend = 1'b0;
          end
          s_next.cnt = s_reg.cnt + 16'h0001;
          s_next.crc = crc_byte(s_reg.crc, rx_in.data);
          if (s_reg.cnt == lp || s_reg.cnt == lp + 16'h0001)
            s_next.lt = ltn;
          if (s_reg.cnt == lp + 16'h0001)
          begin
            if (ltn == `ERF_TYPE_VLAN && !s_reg.svlan)
            begin
              s_next.vlan = 1'b1;
              s_next.svlan = s_reg.vlan;
              s_next.lt_pos = s_reg.lt_pos + `ERF_TAG_BYTES;
            end
            s_next.ctl = ltn == `ERF_TYPE_CTRL;
          end
          if (s_reg.ctl && (s_reg.cnt == lp + 16'h0002 || s_reg.cnt == lp + 16'h0003))
            s_next.op = {s_reg.op[7:0], rx_in.data};
        end
        else if (rx_in.valid && rx_in.data == `ERF_CH_TERM)
        begin
          if (s_reg.crc_keep)
          begin
            s_next.state = ST_DRAIN;
            s_next.hold_err = ferr;
            s_next.hold_stat = fstat;
          end
          else
          begin
            // Frames failing length checks are still delivered
            s_next.state = ST_IDLE;
            s_next.out.valid = 1'b1;
            s_next.out.data = s_reg.dly[4];
            s_next.out.sop = s_reg.sop_pend;
            s_next.out.eop = 1'b1;
            s_next.out.err = ferr;
            s_next.out.stat = fstat;
          end
        end
        else if (rx_in.valid)
        begin
          // Stray control character closes the frame as malformed
          s_next.state = ST_IDLE;
          s_next.out.valid = 1'b1;
          s_next.out.data = s_reg.dly[4];
          s_next.out.sop = s_reg.sop_pend;
          s_next.out.eop = 1'b1;
          s_next.out.err = ferr | 5'h03;
          s_next.out.stat = fstat;
        end
      end
      ST_DRAIN:
      begin
        // Limitation: a start arriving while the FCS drains is missed
        s_next.dly = {s_reg.dly[3:0], 8'h00};
        s_next.dly_v = {s_reg.dly_v[3:0], 1'b0};
        if (s_reg.dly_v[4])
        begin
          s_next.out.valid = 1'b1;
          s_next.out.data = s_reg.dly[4];
          s_next.out.sop = s_reg.sop_pend;
          s_next.sop_pend = 1'b0;
        end
        if (s_reg.dly_v[4] && s_reg.dly_v[3:0] == 4'h0)
        begin
          s_next.out.eop = 1'b1;
          s_next.out.err = s_reg.hold_err;
          s_next.out.stat = s_reg.hold_stat;
        end
        if (s_reg.dly_v[3:0] == 4'h0)
          s_next.state = ST_IDLE;
      end
      ST_DROP:
      begin
        // Discard quietly until the next control character
        if (rx_in.valid && rx_in.ctrl)
          s_next.state = ST_IDLE;
      end
      default: s_next.state = ST_IDLE;
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg <= '0;
      s_reg.state <= ST_IDLE;
      s_reg.cfg_fault <= `ERF_FAULT_CFG_RST;
      s_reg.max_size <= MAX_RX_SIZE;
      s_reg.tx_de <= 1'b1;
      s_reg.lt_pos <= `ERF_LT_POS;
    end
    else
      s_reg <= s_next;
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  fault_track_a: assert property (1'b1 |=> local_fault_status == $past(local_fault_in) && remote_fault_status == $past(remote_fault_in))
    else $error("fault status does not follow link");
  cfg_off_a: assert property (!s_reg.cfg_fault[0] |=> tx_data_enable && !tx_send_rf)
    else $error("disabled signalling still gates tx");
  force_rf_a: assert property (s_reg.cfg_fault[0] && s_reg.cfg_fault[3] |=> !tx_data_enable && tx_send_rf)
    else $error("forced remote fault not sent");
  bidir_lf_a: assert property (s_reg.cfg_fault[3:0] == 4'h1 && s_reg.lf |=> !tx_data_enable && tx_send_rf)
    else $error("local fault did not stop data");
  bidir_rf_a: assert property (s_reg.cfg_fault[3:0] == 4'h1 && !s_reg.lf && s_reg.rf |=> !tx_data_enable && !tx_send_rf)
    else $error("remote fault did not force idle");
  uni_lf_a: assert property (s_reg.cfg_fault[3:0] == 4'h3 && s_reg.lf && !s_reg.rf |=> tx_data_enable && tx_send_rf && tx_idle_column)
    else $error("unidirectional local fault wrong");
  no_start_a: assert property (s_reg.state == ST_IDLE && !(rx_in.valid && rx_in.ctrl && rx_in.data == `ERF_CH_START) |=> s_reg.state == ST_IDLE)
    else $error("packet started without start byte");
  malform_eop_a: assert property (s_reg.state == ST_DATA && rx_in.valid && rx_in.ctrl && rx_in.data != `ERF_CH_TERM |=> rx_out.eop && rx_out.err[1:0] == 2'h3 && s_reg.state == ST_IDLE ##1 !rx_out.eop)
    else $error("malformed packet not closed");
  sfd_drop_a: assert property (s_reg.state == ST_PRE && s_reg.pre_cnt == `ERF_PRE_LEN && rx_in.valid && !rx_in.ctrl && STRICT_EN && s_reg.chk_sfd && rx_in.data != `ERF_SFD |=> s_reg.state == ST_DROP ##1 !rx_out.valid)
    else $error("bad SFD not dropped");
  err_eop_a: assert property (rx_out.err != 5'h00 |-> rx_out.eop && rx_out.valid)
    else $error("error shown outside end of packet");

  good_frame_c: cover property (rx_out.eop && rx_out.err == 5'h00);
  malformed_c: cover property (rx_out.eop && rx_out.err[0]);
  dropped_c: cover property (s_reg.state == ST_DROP);
  vlan_frame_c: cover property (rx_out.eop && rx_out.stat[0]);

endmodule : erf_rx_check
`default_nettype wire

/* erf_client_model.sv */
// Client logic model on the receive streaming side of the frame checker.
// Assumes the checker's registered client stream and the package types.
`timescale 1ns/1ps
`default_nettype none
module erf_client_model
  import erf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire erf_client_t rx_out,
  output logic [4:0] last_err,
  output logic [4:0] last_stat,
  output logic [15:0] beats,
  output logic [15:0] eops,
  output logic [15:0] sops,
  output logic [7:0] first_data,
  output logic [7:0] last_data
);
  // ********
  // Sink
  // ********
  // Counts beats and ends; error and kind are taken only on the end beat,
  // the client decides itself what to discard
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_err <= 5'h00;
      last_stat <= 5'h00;
      beats <= 16'h0000;
      eops <= 16'h0000;
      sops <= 16'h0000;
      first_data <= 8'h00;
      last_data <= 8'h00;
    end
    else
    begin
      if (rx_out.valid)
        beats <= beats + 16'h0001;
      // Start beat opens a frame; its byte shows where the stream began
      if (rx_out.valid && rx_out.sop)
      begin
        sops <= sops + 16'h0001;
        first_data <= rx_out.data;
      end
      // End beat carries the flags
      if (rx_out.eop)
      begin
        eops <= eops + 16'h0001;
        last_err <= rx_out.err;
        last_stat <= rx_out.stat;
        last_data <= rx_out.data;
      end
    end
  end
endmodule : erf_client_model
`default_nettype wire

/* eth_rx_frame_checker_fault_signaling_tb.sv */
// Self-checking bench for the receive frame checker and fault gating.
// Assumes erf_cfg.svh on the include path and the client model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "erf_cfg.svh"
module eth_rx_frame_checker_fault_signaling_tb
  import erf_pkg::*;
;
  localparam logic [7:0] ST = `ERF_CH_START;
  localparam logic [7:0] TM = `ERF_CH_TERM;
  localparam logic [7:0] PB = `ERF_PRE_BYTE;
  localparam logic [7:0] SF = `ERF_SFD;
  logic pclk, presetn, psel, penable, pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, se;
  erf_link_t rx_in;
  erf_client_t rx_out;
  logic lf_in, rf_in, lf_st, rf_st, tx_de, tx_rf, tx_ic;
  logic [4:0] c_err, c_stat;
  logic [15:0] c_beats, c_eops, b0, e0, c_sops, s0;
  logic [7:0] c_first, c_last;
  int error_cnt, tests_run, cyc;
  // Fault cases: {config[3:0], lf, rf, data on, rf on, idle column}
  logic [8:0] ftab [9] = '{9'h014, 9'h122, 9'h0f4, 9'h077, 9'h06c, 9'h032, 9'h028, 9'h024, 9'h03a};

  erf_rx_check #(.STRICT_EN(1'b1), .MAX_RX_SIZE(`ERF_MAX_SIZE_RST)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_in(rx_in), .local_fault_in(lf_in), .remote_fault_in(rf_in), .rx_out(rx_out),
    .local_fault_status(lf_st), .remote_fault_status(rf_st), .tx_data_enable(tx_de),
    .tx_send_rf(tx_rf), .tx_idle_column(tx_ic));
  erf_client_model cm (.pclk(pclk), .presetn(presetn), .rx_out(rx_out), .last_err(c_err),
    .last_stat(c_stat), .beats(c_beats), .eops(c_eops), .sops(c_sops), .first_data(c_first),
    .last_data(c_last));

  // ********
  // Clock and watchdog
  // ********
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Whole run needs a few thousand cycles; the ceiling leaves wide margin
  always @(posedge pclk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      results();
    end
  end

  // ********
  // Tasks
  // ********
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One APB transfer; holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [13:0] idx, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge pclk);
      t++;
    end
    while (pready !== 1'b1 && t < 50);
    if (pready !== 1'b1)
      chk("apb_ready", 1, 0);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic ch(input logic c, input logic [7:0] d);
    @(posedge pclk);
    rx_in <= '{valid: 1'b1, ctrl: c, data: d};
  endtask : ch
  // Reflected CRC32 of one byte, worked out on the bench side
  function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h0, b};
    for (int i = 0; i < 8; i++)
      r = r[0] ? (r >> 1) ^ `ERF_CRC_POLY : r >> 1;
    return r;
  endfunction : crc8
  // Sends one packet of n frame bytes plus FCS, then checks what the client saw
  task automatic send(input int n, input logic [15:0] lt, op, input logic [7:0] st, pb, sf, ec,
                      input bit bad, input int ne, nb, input logic [4:0] er, stt);
    logic [7:0] b;
    logic [31:0] c;
    b0 = c_beats;
    e0 = c_eops;
    s0 = c_sops;
    c = 32'hffffffff;
    ch(1'b1, st);
    repeat (6) ch(1'b0, pb);
    ch(1'b0, sf);
    for (int k = 0; k < n; k++)
    begin
      b = (k == 12) ? lt[15:8] : (k == 13) ? lt[7:0] : (k == 14) ? op[15:8] : (k == 15) ? op[7:0] : 8'(k);
      ch(1'b0, b);
      c = crc8(c, b);
    end
    c = ~c ^ {31'h0, bad};
    for (int k = 0; k < 4; k++)
      ch(1'b0, c[8*k +: 8]);
    ch(1'b1, ec);
    // A terminate after a stray control must not end a second time
    if (ec !== TM)
      ch(1'b1, TM);
    @(posedge pclk);
    rx_in <= '0;
    repeat (20) @(posedge pclk);
    chk("eop_count", ne, 32'(c_eops - e0));
    chk("sop_count", ne, 32'(c_sops - s0));
    if (nb >= 0)
      chk("beat_count", nb, 32'(c_beats - b0));
    if (ne > 0)
    begin
      chk("rx_err", er, c_err);
      chk("rx_stat", stt, c_stat);
      chk("first_byte", 32'h0, {24'h0, c_first});
      // Stripped frames end on the last frame byte, kept ones on the top FCS byte
      chk("last_byte", {24'h0, (nb == n) ? 8'(n - 1) : c[31:24]}, {24'h0, c_last});
    end
  endtask : send
  task automatic results();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  // ********
  // Main sequence
  // ********
  initial
  begin
    {presetn, psel, penable, pwrite, lf_in, rf_in} = 6'h00;
    paddr = 16'h0000;
    pwdata = 32'h0;
    rx_in = '0;
    error_cnt = 0;
    tests_run = 0;
    cyc = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `ERF_IDX_FAULT_CFG, 32'h0); chk("fault_cfg_rst", 32'h0, rd);
    apb(1'b0, `ERF_IDX_RX_CTL, 32'h0); chk("rx_ctl_rst", 32'h0, rd);
    apb(1'b0, `ERF_IDX_MAX_SIZE, 32'h0); chk("max_size_rst", 32'h5ee, rd);
    apb(1'b0, 14'h0100, 32'h0); chk("unmapped_err", 32'h1, {31'h0, se});
    send(60, 16'h002e, 16'h0, ST, PB, SF, TM, 0, 1, 60, 5'h00, 5'h00);
    send(60, 16'h002e, 16'h0, ST, PB, SF, TM, 1, 1, 60, 5'h02, 5'h00);
    send(56, 16'h002e, 16'h0, ST, PB, SF, TM, 0, 1, 56, 5'h14, 5'h00);
    send(64, 16'h002e, 16'h0, ST, PB, SF, TM, 0, 1, 64, 5'h00, 5'h00);
    send(60, 16'h8808, 16'h0001, ST, PB, SF, TM, 0, 1, 60, 5'h00, 5'h0c);
    send(60, 16'h8808, 16'h0101, ST, PB, SF, TM, 0, 1, 60, 5'h00, 5'h14);
    send(60, 16'h8808, 16'h0002, ST, PB, SF, TM, 0, 1, 60, 5'h00, 5'h04);
    send(60, 16'h0800, 16'h0, ST, PB, SF, TM, 0, 1, 60, 5'h00, 5'h00);
    apb(1'b1, `ERF_IDX_MAX_SIZE, 32'd100);
    apb(1'b0, `ERF_IDX_MAX_SIZE, 32'h0); chk("max_size_wr", 32'd100, rd);
    send(96, 16'd82, 16'h0, ST, PB, SF, TM, 0, 1, 96, 5'h00, 5'h00);
    send(100, 16'd86, 16'h0, ST, PB, SF, TM, 0, 1, 100, 5'h08, 5'h00);
    // Same size with one tag stays inside the limit
    send(100, 16'h8100, 16'h0, ST, PB, SF, TM, 0, 1, 100, 5'h00, 5'h01);
    send(60, 16'h002e, 16'h0, ST, PB, SF, 8'h07, 0, 1, 60, 5'h03, 5'h00);
    send(60, 16'h002e, 16'h0, ST, PB, SF, 8'hfe, 0, 1, 60, 5'h03, 5'h00);
    send(60, 16'h002e, 16'h0, 8'hfc, PB, SF, TM, 0, 0, 0, 5'h00, 5'h00);
    send(60, 16'h002e, 16'h0, ST, 8'h54, 8'hd4, TM, 0, 1, 60, 5'h00, 5'h00);
    apb(1'b1, `ERF_IDX_RX_CTL, 32'h08);
    send(60, 16'h002e, 16'h0, ST, PB, 8'hd4, TM, 0, 0, 0, 5'h00, 5'h00);
    send(60, 16'h002e, 16'h0, ST, 8'h54, SF, TM, 0, 1, 60, 5'h00, 5'h00);
    apb(1'b1, `ERF_IDX_RX_CTL, 32'h10);
    send(60, 16'h002e, 16'h0, ST, 8'h54, SF, TM, 0, 0, 0, 5'h00, 5'h00);
    send(60, 16'h002e, 16'h0, ST, PB, 8'hd4, TM, 0, 1, 60, 5'h00, 5'h00);
    apb(1'b1, `ERF_IDX_RX_CTL, 32'h18);
    send(60, 16'h002e, 16'h0, ST, PB, SF, TM, 0, 1, 60, 5'h00, 5'h00);
    apb(1'b1, `ERF_IDX_CRC_KEEP, 32'h1);
    send(60, 16'h002e, 16'h0, ST, PB, SF, TM, 0, 1, 64, 5'h00, 5'h00);
    // Fault gating across configuration and link state
    for (int i = 0; i < 9; i++)
    begin
      apb(1'b1, `ERF_IDX_FAULT_CFG, {28'h0, ftab[i][8:5]});
      lf_in <= ftab[i][4];
      rf_in <= ftab[i][3];
      repeat (3) @(posedge pclk);
      chk("lf_status", {31'h0, ftab[i][4]}, {31'h0, lf_st});
      chk("rf_status", {31'h0, ftab[i][3]}, {31'h0, rf_st});
      chk("tx_data", {31'h0, ftab[i][2]}, {31'h0, tx_de});
      chk("tx_rf", {31'h0, ftab[i][1]}, {31'h0, tx_rf});
      chk("tx_idle_col", {31'h0, ftab[i][0]}, {31'h0, tx_ic});
    end
    // Last case leaves both faults up and the receiver idle
    apb(1'b0, `ERF_IDX_STATUS, 32'h0); chk("status_reg", 32'h3, rd);
    results();
  end
endmodule : eth_rx_frame_checker_fault_signaling_tb
`default_nettype wire
